// ===== rtl/cms_clock_seq.v
/*
  controller that brings up the device's 4x clock multiplier and clock
  selection through the device register port, ordered by software over a
  plain local register port.
  assumes one 10 MHz clock; device answers reads one cycle after dev_rd_out.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cms_regs.vh"

// Behaviour
// RL1: device multiplier gives four times its input, 12 MHz to 48 MHz.
// RL2: device offers divided multiplier output as a system clock source.
// RL3: bring-up starts by writing zero to multiplier control, resetting it.
// RL4: input select bits 1..0: 00 internal, 01 external, 10 external/2, 11 reserved.
// RL5: bit 7 enables multiplier; set after input select by OR-ing 0x80.
// RL6: wait over 5 us after enable, then OR 0xC0 to initialize.
// RL7: ready flag bit 5 reads 1 once stable; poll before use.
// RL8: external source must be enabled and settled before initializing.
// RL9: internal oscillator usable at once after enabling write.
// RL10: device sets crystal settled flag when external oscillator settles.
// RL11: in crystal mode wait 1 ms before checking settled flag.
// RL12: system select 01 picks external oscillator.
// RL13: switch system clock only to an enabled, settled source; code polls the external settled flag only when input select is not 00.
// RL14: three-bit usb select picks multiplier or divided oscillators.
// RL15: usb clock 48 MHz full speed, 6 MHz low speed.
// RL16: full speed internal: usb 000, input 00, divider 11, recovery on.
// RL17: full speed crystal: usb 000, input 01, mode 110, drive 111.
// RL18: ready flag clears on reset or disable until re-initialized.
// RL19: reserved input code never gives a ready multiplier.
module cms_clock_seq #(
  parameter XTAL_WAIT_CYC = (`CMS_XTAL_WAIT_US * (`CMS_CLK_HZ / 1000000)),
  parameter POLL_LIMIT = 1000
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire [3:0] addr_in,
  input wire [15:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [15:0] rdata_out,
  output wire [7:0] dev_addr_out,
  output wire [7:0] dev_wdata_out,
  output wire dev_wr_out,
  output wire dev_rd_out,
  input wire [7:0] dev_rdata_in
);

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
// least time rounds up, plus one cycle to make it strictly greater
localparam EN_WAIT_CYC = (`CMS_EN_WAIT_NS * (`CMS_CLK_HZ / 1000000) + 999) / 1000 + 1;

// ------------------------------------------------------------
// states
// ------------------------------------------------------------
localparam [10:0] S_IDLE = 11'h001;
localparam [10:0] S_RESET = 11'h002;
localparam [10:0] S_XWAIT = 11'h004;
localparam [10:0] S_XPOLL = 11'h008;
localparam [10:0] S_SEL = 11'h010;
localparam [10:0] S_EN = 11'h020;
localparam [10:0] S_ENW = 11'h040;
localparam [10:0] S_INIT = 11'h080;
localparam [10:0] S_RPOLL = 11'h100;
localparam [10:0] S_CLOCK_SOURCE_SELECT_REG = 11'h200;
localparam [10:0] S_DIRECT = 11'h400;

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg [10:0] state_r, state_nxt;
reg [15:0] ctrl_r;
reg busy_r, done_r, err_r, rdy_r, xtal_r;
reg [15:0] polls_r;
reg issued_r;
reg [7:0] dev_rd_r;
wire [1:0] sel_w = ctrl_r[`CMS_CTRL_SEL_MSB:`CMS_CTRL_SEL_LSB];
wire [7:0] mul_base_w = {6'h00, sel_w};

// ------------------------------------------------------------
// sub-blocks
// ------------------------------------------------------------
reg port_wr, port_rd, tmr_start;
reg [7:0] port_addr, port_wdata;
reg [15:0] tmr_count;
wire port_done, tmr_done;
wire [7:0] port_rdata;

cms_dev_port u_port (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .wr_req_in(port_wr),
  .rd_req_in(port_rd),
  .addr_in(port_addr),
  .wdata_in(port_wdata),
  .dev_rdata_in(dev_rdata_in),
  .dev_addr_out(dev_addr_out),
  .dev_wdata_out(dev_wdata_out),
  .dev_wr_out(dev_wr_out),
  .dev_rd_out(dev_rd_out),
  .rdata_out(port_rdata),
  .done_out(port_done)
);

cms_wait_timer #(.W(16)) u_tmr (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .start_in(tmr_start),
  .count_in(tmr_count),
  .done_out(tmr_done)
);

// ------------------------------------------------------------
// sequencer
// ------------------------------------------------------------
always @* begin
  state_nxt = state_r;
  port_wr = 1'b0;
  port_rd = 1'b0;
  port_addr = `CMS_MUL_CTRL_ADDR;
  port_wdata = `CMS_MUL_RESET_VAL;
  tmr_start = 1'b0;
  tmr_count = 16'h0000;
  case (state_r)
    S_IDLE: begin
      if (wr_in && addr_in == `CMS_R_CTRL && (wdata_in[`CMS_CTRL_DEVW] | wdata_in[`CMS_CTRL_DEVR])) begin
        state_nxt = S_DIRECT;
      end else if (wr_in && addr_in == `CMS_R_CTRL && wdata_in[`CMS_CTRL_START]) begin
        state_nxt = S_RESET;
      end
    end
    S_RESET: begin
      port_wr = ~issued_r; // see RL3
      port_wdata = `CMS_MUL_RESET_VAL;
      if (port_done) begin
        if (sel_w == `CMS_MUL_SEL_RSVD) begin
          state_nxt = S_IDLE; // see RL19
        end else if (sel_w != 2'b00 && ctrl_r[`CMS_CTRL_XTAL]) begin
          tmr_start = 1'b1; // see RL11 RL17
          tmr_count = XTAL_WAIT_CYC[15:0];
          state_nxt = S_XWAIT;
        end else if (sel_w != 2'b00) begin
          state_nxt = S_XPOLL;
        end else begin
          state_nxt = S_SEL; // see RL9 RL16
        end
      end
    end
    S_XWAIT: begin
      if (tmr_done) begin
        state_nxt = S_XPOLL;
      end
    end
    S_XPOLL: begin
      port_rd = ~issued_r; // see RL8
      port_addr = `CMS_XOSC_CTRL_ADDR;
      if (port_done && port_rdata[`CMS_XTAL_OK_BIT]) begin
        state_nxt = S_SEL; // see RL10
      end else if (port_done && polls_r >= POLL_LIMIT[15:0]) begin
        state_nxt = S_IDLE;
      end
    end
    S_SEL: begin
      port_wr = ~issued_r; // see RL4
      port_wdata = mul_base_w;
      if (port_done) begin
        state_nxt = S_EN;
      end
    end
    S_EN: begin
      port_wr = ~issued_r; // see RL5
      port_wdata = mul_base_w | `CMS_MUL_EN_OR;
      if (port_done) begin
        tmr_start = 1'b1; // see RL6
        tmr_count = EN_WAIT_CYC[15:0];
        state_nxt = S_ENW;
      end
    end
    S_ENW: begin
      if (tmr_done) begin
        state_nxt = S_INIT;
      end
    end
    S_INIT: begin
      port_wr = ~issued_r; // see RL6
      port_wdata = mul_base_w | `CMS_MUL_INIT_OR;
      if (port_done) begin
        state_nxt = S_RPOLL;
      end
    end
    S_RPOLL: begin
      port_rd = ~issued_r; // see RL7
      if (port_done && port_rdata[`CMS_MUL_RDY_BIT]) begin
        state_nxt = S_CLOCK_SOURCE_SELECT_REG;
      end else if (port_done && polls_r >= POLL_LIMIT[15:0]) begin
        state_nxt = S_IDLE;
      end
    end
    S_CLOCK_SOURCE_SELECT_REG: begin
      port_wr = ~issued_r; // see RL13
      port_addr = `CMS_CLK_SEL_ADDR;
      port_wdata = {1'b0, ctrl_r[`CMS_CTRL_USB_MSB:`CMS_CTRL_USB_LSB], 2'b00,
                    ctrl_r[`CMS_CTRL_SYS_MSB:`CMS_CTRL_SYS_LSB]}; // see RL14 RL15
      if (port_done) begin
        state_nxt = S_IDLE;
      end
    end
    S_DIRECT: begin
      port_wr = ~issued_r & ctrl_r[`CMS_CTRL_DEVW];
      port_rd = ~issued_r & ~ctrl_r[`CMS_CTRL_DEVW];
      port_addr = ctrl_r[15:8] & 8'h00 | {ctrl_r[7:0]};
      port_wdata = dev_rd_r;
      if (port_done) begin
        state_nxt = S_IDLE;
      end
    end
    default: begin
      state_nxt = S_IDLE;
    end
  endcase
end

// ------------------------------------------------------------
// state, status and local registers
// ------------------------------------------------------------
always @(posedge ref_clk_in or posedge rst_in) begin
  if (rst_in) begin
    state_r <= S_IDLE;
    ctrl_r <= 16'h0000;
    busy_r <= 1'b0;
    done_r <= 1'b0;
    err_r <= 1'b0;
    rdy_r <= 1'b0;
    xtal_r <= 1'b0;
    polls_r <= 16'h0000;
    issued_r <= 1'b0;
    dev_rd_r <= 8'h00;
  end else begin
    state_r <= state_nxt;
    if (state_nxt != state_r) begin
      issued_r <= 1'b0;
    end else if (port_wr | port_rd) begin
      issued_r <= 1'b1;
    end else if (port_done) begin
      issued_r <= 1'b0;
    end
    if (state_nxt != state_r) begin
      polls_r <= 16'h0000;
    end else if (port_done) begin
      polls_r <= polls_r + 16'h0001;
    end
    if (state_r == S_IDLE && wr_in && addr_in == `CMS_R_CTRL) begin
      ctrl_r <= wdata_in;
      if (wdata_in[`CMS_CTRL_START] && !(wdata_in[`CMS_CTRL_DEVW] | wdata_in[`CMS_CTRL_DEVR])) begin
        busy_r <= 1'b1;
        done_r <= 1'b0;
        err_r <= 1'b0;
      end
    end
    if (state_r == S_IDLE && wr_in && addr_in == `CMS_R_DEV_RDATA) begin
      dev_rd_r <= wdata_in[7:0];
    end
    if (state_r == S_RESET && port_done) begin
      rdy_r <= 1'b0; // see RL18
      if (sel_w == `CMS_MUL_SEL_RSVD) begin
        busy_r <= 1'b0;
        err_r <= 1'b1; // see RL19
      end
    end
    if (state_r == S_XPOLL && port_done) begin
      xtal_r <= port_rdata[`CMS_XTAL_OK_BIT];
    end
    if ((state_r == S_XPOLL || state_r == S_RPOLL) && state_nxt == S_IDLE) begin
      busy_r <= 1'b0;
      err_r <= 1'b1;
    end
    if (state_r == S_RPOLL && port_done && port_rdata[`CMS_MUL_RDY_BIT]) begin
      rdy_r <= 1'b1; // see RL7
    end
    if (state_r == S_CLOCK_SOURCE_SELECT_REG && port_done) begin
      busy_r <= 1'b0;
      done_r <= 1'b1; // see RL2
    end
    if (state_r == S_DIRECT && port_done && ~ctrl_r[`CMS_CTRL_DEVW]) begin
      dev_rd_r <= port_rdata;
    end
  end
end

// ------------------------------------------------------------
// local read port
// ------------------------------------------------------------
always @(posedge ref_clk_in or posedge rst_in) begin
  if (rst_in) begin
    rdata_out <= 16'h0000;
  end else if (rd_in) begin
    case (addr_in)
      `CMS_R_CTRL: rdata_out <= ctrl_r;
      `CMS_R_STAT: rdata_out <= {11'h000, xtal_r, rdy_r, err_r, done_r, busy_r};
      `CMS_R_DEV_RDATA: rdata_out <= {8'h00, dev_rd_r};
      default: rdata_out <= 16'h0000;
    endcase
  end else begin
    rdata_out <= 16'h0000;
  end
end

endmodule // cms_clock_seq
`default_nettype wire

// ===== rtl/cms_regs.vh
/*
  constants for the clock multiplier sequencing controller: device register
  offsets, field positions, codes, timing, and the controller's own map.
  assumes inclusion by bare name from the rtl files.
*/
`ifndef CMS_REGS_VH
`define CMS_REGS_VH

// ------------------------------------------------------------
// device register offsets
// ------------------------------------------------------------
`define CMS_MUL_CTRL_ADDR 8'hB9
`define CMS_CLK_SEL_ADDR 8'hA9
`define CMS_XOSC_CTRL_ADDR 8'hB1
`define CMS_IOSC_CTRL_ADDR 8'hB2

// ------------------------------------------------------------
// multiplier control fields and values
// ------------------------------------------------------------
`define CMS_MUL_RESET_VAL 8'h00
`define CMS_MUL_EN_OR 8'h80
`define CMS_MUL_INIT_OR 8'hC0
`define CMS_MUL_EN_BIT 7
`define CMS_MUL_INIT_BIT 6
`define CMS_MUL_RDY_BIT 5
`define CMS_MUL_SEL_MSB 1
`define CMS_MUL_SEL_LSB 0
`define CMS_MUL_SEL_RSVD 2'b11

// ------------------------------------------------------------
// clock select fields and crystal settled flag
// ------------------------------------------------------------
`define CMS_USB_SEL_MSB 6
`define CMS_USB_SEL_LSB 4
`define CMS_SYS_SEL_MSB 1
`define CMS_SYS_SEL_LSB 0
`define CMS_SYS_SEL_MUL 2'b10
`define CMS_XTAL_OK_BIT 7
`define CMS_USB_SEL_RSVD_MSB 3'b110

// ------------------------------------------------------------
// timing (10 MHz clock)
// ------------------------------------------------------------
`define CMS_CLK_HZ 10000000
`define CMS_EN_WAIT_NS 5000
`define CMS_XTAL_WAIT_US 1000

// ------------------------------------------------------------
// controller register map (word offsets on the local port)
// ------------------------------------------------------------
`define CMS_R_CTRL 4'h0
`define CMS_R_STAT 4'h1
`define CMS_R_DEV_RDATA 4'h2
`define CMS_CTRL_START 0
`define CMS_CTRL_XTAL 1
`define CMS_CTRL_SEL_LSB 2
`define CMS_CTRL_SEL_MSB 3
`define CMS_CTRL_SYS_LSB 4
`define CMS_CTRL_SYS_MSB 5
`define CMS_CTRL_USB_LSB 8
`define CMS_CTRL_USB_MSB 10
`define CMS_CTRL_DEVW 11
`define CMS_CTRL_DEVR 12
`define CMS_ST_BUSY 0
`define CMS_ST_DONE 1
`define CMS_ST_ERR 2
`define CMS_ST_RDY 3
`define CMS_ST_XTAL 4

`endif

// ===== rtl/cms_wait_timer.v
/*
  down counter for settling waits.
  assumes a single clock and start pulses from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none

module cms_wait_timer #(
  parameter W = 16
) (
  input wire ref_clk_in,
  input wire rst_in,
  input wire start_in,
  input wire [W-1:0] count_in,
  output wire done_out
);

// ------------------------------------------------------------
// counter
// ------------------------------------------------------------
reg [W-1:0] cnt_r;
reg run_r;

always @(posedge ref_clk_in or posedge rst_in) begin
  if (rst_in) begin
    cnt_r <= {W{1'b0}};
    run_r <= 1'b0;
  end else if (start_in) begin
    cnt_r <= count_in;
    run_r <= 1'b1;
  end else if (run_r && cnt_r != {W{1'b0}}) begin
    cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end else begin
    run_r <= 1'b0;
  end
end

assign done_out = run_r && (cnt_r == {W{1'b0}});

endmodule // cms_wait_timer
`default_nettype wire

// ===== rtl/cms_dev_port.v
/*
  device register access engine: one write or read per request.
  assumes device read data valid the cycle after dev_rd_out.
*/
`timescale 1ns/1ps
`default_nettype none

module cms_dev_port (
  input wire ref_clk_in,
  input wire rst_in,
  input wire wr_req_in,
  input wire rd_req_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] dev_rdata_in,
  output reg [7:0] dev_addr_out,
  output reg [7:0] dev_wdata_out,
  output reg dev_wr_out,
  output reg dev_rd_out,
  output reg [7:0] rdata_out,
  output reg done_out
);

// ------------------------------------------------------------
// strobe and capture
// ------------------------------------------------------------
// read answer stands in the cycle after the strobe
reg rd_pend_r;

always @(posedge ref_clk_in or posedge rst_in) begin
  if (rst_in) begin
    rd_pend_r <= 1'b0;
    dev_addr_out <= 8'h00;
    dev_wdata_out <= 8'h00;
    dev_wr_out <= 1'b0;
    dev_rd_out <= 1'b0;
    rdata_out <= 8'h00;
    done_out <= 1'b0;
  end else begin
    dev_wr_out <= wr_req_in;
    dev_rd_out <= rd_req_in & ~wr_req_in;
    rd_pend_r <= dev_rd_out;
    done_out <= dev_wr_out | rd_pend_r;
    if (wr_req_in | rd_req_in) begin
      dev_addr_out <= addr_in;
      dev_wdata_out <= wdata_in;
    end
    if (rd_pend_r) begin
      rdata_out <= dev_rdata_in;
    end
  end
end

endmodule // cms_dev_port
`default_nettype wire

// ===== test/cms_clock_seq_props.sv
/* assertions on the ports of cms_clock_seq.
   assumes the bind below and reads answered one cycle after dev_rd_out. */
`timescale 1ns/1ps
`default_nettype none
module cms_clock_seq_props #(
  parameter XTAL_WAIT_CYC = 10000,
  parameter POLL_LIMIT = 1000
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [7:0] dev_addr_out,
  input wire logic [7:0] dev_wdata_out,
  input wire logic dev_wr_out,
  input wire logic dev_rd_out,
  input wire logic [7:0] dev_rdata_in
);
  logic [7:0] last_mul_r;
  logic [7:0] en_cnt_r;
  logic [7:0] rd_addr_r;
  logic rd_pend_r;
  logic rdy_seen_r;
  logic xt_seen_r;
  wire mul_wr = dev_wr_out && dev_addr_out == 8'hb9;
  wire rdy_hit = rd_pend_r && rd_addr_r == 8'hb9 && dev_rdata_in[5];
  wire xt_hit = rd_pend_r && rd_addr_r == 8'hb1 && dev_rdata_in[7];
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_mul_r <= 8'h00;
      en_cnt_r <= 8'h00;
      rd_addr_r <= 8'h00;
      rd_pend_r <= 1'b0;
      rdy_seen_r <= 1'b0;
      xt_seen_r <= 1'b0;
    end else begin
      rd_pend_r <= dev_rd_out;
      rd_addr_r <= dev_addr_out;
      if (mul_wr) last_mul_r <= dev_wdata_out;
      if (mul_wr) en_cnt_r <= 8'h00;
      else if (en_cnt_r != 8'hff) en_cnt_r <= en_cnt_r + 8'h01;
      if (mul_wr) rdy_seen_r <= 1'b0;
      else if (rdy_hit) rdy_seen_r <= 1'b1;
      if (mul_wr && dev_wdata_out == 8'h00) xt_seen_r <= 1'b0;
      else if (xt_hit) xt_seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_DEV_SPACING: assert property ((dev_wr_out || dev_rd_out) |=> !(dev_wr_out || dev_rd_out) [*2])
    else $error("device accesses closer than three cycles");
  AST_SEL_AFTER_RESET: assert property (mul_wr && !dev_wdata_out[7] && dev_wdata_out != 8'h00 |-> last_mul_r == 8'h00)
    else $error("input select written without a prior reset write");
  AST_EN_AFTER_SEL: assert property (mul_wr && dev_wdata_out[7:6] == 2'b10 |-> last_mul_r == {6'h00, dev_wdata_out[1:0]})
    else $error("enable not preceded by the input select write");
  AST_INIT_WAIT: assert property (mul_wr && dev_wdata_out[6] |-> last_mul_r == (dev_wdata_out & 8'hbf) && en_cnt_r >= 8'h32)
    else $error("initialize too early or not after enable");
  AST_RSVD: assert property (mul_wr && dev_wdata_out[7] |-> dev_wdata_out[1:0] != 2'b11)
    else $error("multiplier enabled on the reserved input");
  AST_SYS_AFTER_RDY: assert property (dev_wr_out && dev_addr_out == 8'ha9 |-> rdy_seen_r)
    else $error("clock select written before ready was seen");
  AST_XT_BEFORE_INIT: assert property (mul_wr && dev_wdata_out[6] && dev_wdata_out[1:0] != 2'b00 |-> xt_seen_r)
    else $error("initialize on external input before it settled");
endmodule // cms_clock_seq_props
bind cms_clock_seq cms_clock_seq_props #(.XTAL_WAIT_CYC(XTAL_WAIT_CYC), .POLL_LIMIT(POLL_LIMIT)) u_props (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out),
  .dev_wr_out(dev_wr_out), .dev_rd_out(dev_rd_out), .dev_rdata_in(dev_rdata_in));
`default_nettype wire

// ===== test/cms_dev_model.sv
/* behavioural model of the device clock registers.
   assumes one clock; answers a read in the cycle after the strobe. */
`timescale 1ns/1ps
`default_nettype none
module cms_dev_model #(
  parameter LOCK_CYC = 30,
  parameter XT_SETTLE = 200
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] dev_addr_in,
  input wire logic [7:0] dev_wdata_in,
  input wire logic dev_wr_in,
  input wire logic dev_rd_in,
  output logic [7:0] dev_rdata_out
);
  logic [7:0] mul_ctrl_r;
  logic [7:0] clk_sel_r;
  logic [7:0] lock_cnt_r;
  logic [7:0] xt_cnt_r;
  wire run = mul_ctrl_r[7:6] == 2'b11 && mul_ctrl_r[1:0] != 2'b11;
  wire locked = run && lock_cnt_r == 8'(LOCK_CYC);
  wire xt_ok = xt_cnt_r == 8'(XT_SETTLE);
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mul_ctrl_r <= 8'h00;
      clk_sel_r <= 8'h00;
      lock_cnt_r <= 8'h00;
      xt_cnt_r <= 8'h00;
      dev_rdata_out <= 8'h00;
    end else begin
      if (dev_wr_in && dev_addr_in == 8'hb9) begin
        mul_ctrl_r <= dev_wdata_in & 8'hc3;
        lock_cnt_r <= 8'h00;
      end else if (run && !locked) begin
        lock_cnt_r <= lock_cnt_r + 8'h01;
      end
      if (dev_wr_in && dev_addr_in == 8'ha9) clk_sel_r <= dev_wdata_in & 8'h73;
      if (!xt_ok) xt_cnt_r <= xt_cnt_r + 8'h01;
      if (dev_rd_in) begin
        case (dev_addr_in)
          8'hb9: dev_rdata_out <= {mul_ctrl_r[7:6], locked, 3'h0, mul_ctrl_r[1:0]};
          8'ha9: dev_rdata_out <= clk_sel_r;
          8'hb1: dev_rdata_out <= {xt_ok, 7'h00};
          default: dev_rdata_out <= 8'h00;
        endcase
      end else begin
        dev_rdata_out <= ~dev_rdata_out;
      end
    end
  end
endmodule // cms_dev_model
`default_nettype wire

// ===== test/clock_multiplier_and_select_tb.sv
/* self-checking bench for cms_clock_seq with a device model.
   assumes the checker is bound and the local port answers reads a cycle later. */
`timescale 1ns/1ps
`default_nettype none
module clock_multiplier_and_select_tb;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  wire [15:0] rdata_out;
  wire [7:0] dev_addr_out;
  wire [7:0] dev_wdata_out;
  wire [7:0] dev_rdata_in;
  wire dev_wr_out;
  wire dev_rd_out;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [15:0] st;
  cms_clock_seq #(.XTAL_WAIT_CYC(20), .POLL_LIMIT(1000)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .dev_addr_out(dev_addr_out), .dev_wdata_out(dev_wdata_out), .dev_wr_out(dev_wr_out),
    .dev_rd_out(dev_rd_out), .dev_rdata_in(dev_rdata_in));
  cms_dev_model #(.LOCK_CYC(30), .XT_SETTLE(200)) dev (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .dev_addr_in(dev_addr_out), .dev_wdata_in(dev_wdata_out), .dev_wr_in(dev_wr_out),
    .dev_rd_in(dev_rd_out), .dev_rdata_out(dev_rdata_in));
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic wait_idle();
    st = 16'h0001;
    for (int i = 0; i < 4000 && st[0] !== 1'b0; i++) rd(4'h1, st);
  endtask
  task automatic expect_up(input logic [1:0] sel, input logic [1:0] sys, input logic [2:0] usb);
    if (sel == 2'b11) begin
      chk("status error", 16'h0004, st & 16'h000c);
    end else begin
      chk("status done ready", 16'h000a, st & 16'h000e);
      chk("clock select", {9'h000, usb, 2'h0, sys}, {8'h00, dev.clk_sel_r});
    end
  endtask
  task automatic t_reset();
    rd(4'h1, st);
    chk("status after reset", 16'h0000, st);
    rd(4'hf, st);
    chk("unmapped read", 16'h0000, st);
    chk("multiplier control reset", 16'h0000, {8'h00, dev.mul_ctrl_r});
    $display("test reset finished");
  endtask
  task automatic t_crystal();
    wr(4'h0, 16'h0017);
    wr(4'h0, 16'h0021);
    wait_idle();
    expect_up(2'b01, 2'b01, 3'b000);
    chk("crystal status", 16'h0010, st & 16'h0010);
    $display("test crystal finished");
  endtask
  task automatic t_internal();
    wr(4'h0, 16'h0021);
    wait_idle();
    expect_up(2'b00, 2'b10, 3'b000);
    $display("test internal finished");
  endtask
  task automatic t_codes();
    logic [2:0] c;
    for (int i = 0; i < 6; i++) begin
      c = 3'(i);
      wr(4'h0, {5'h00, c, 2'h0, 2'(i % 3), c[1:0], 2'b01});
      wait_idle();
      expect_up(c[1:0], 2'(i % 3), c);
    end
    $display("test codes finished");
  endtask
  task automatic t_drop();
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h08b9);
    wait_idle();
    wr(4'h2, 16'h00a5);
    wr(4'h0, 16'h10b9);
    repeat (6) @(posedge ref_clk_in);
    rd(4'h2, st);
    chk("ready after reset write", 16'h0000, st);
    $display("test drop finished");
  endtask
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_crystal();
    t_internal();
    t_codes();
    t_drop();
    test_done();
  end
endmodule // clock_multiplier_and_select_tb
`default_nettype wire
